// *** core/fpa_flash_prefetch_accelerator.sv ***
// flash prefetch accelerator: line buffers, prefetch, stall control
//
// Contract
// - one flash bank, four 128-bit buffers
// - line holds four words; word mux selects
// - protection bit 0 splits instruction/data
// - instruction miss stalls, reads whole line
// - pending prefetch hit waits, no reread
// - prefetch next line after each code line fetch or claim, except with mode off
// - prefetched line kept until claimed or a code miss
// - sequential in-line accesses need no flash in mode 2
// - data miss aborts, then restarts prefetch
// - flash read length is programmable
// - quarter access time means no stalls
// - branch target loads branch-trail buffer
// - branch miss stalls while trail loads
// - address latch incrementer forms next line
// - per-buffer latch, comparator, wait logic
// - two-bit mode field, resets off
// - timing field 1..7, resets to 7
// - mode change invalidates all buffers
// - program/erase invalidates, busy holds core
`timescale 1ns/1ps
module fpa_flash_prefetch_accelerator
(
    // clock and reset
    input  wire logic                        ref_clk,
    input  wire logic                        resetn,
    // configuration
    input  wire logic [1:0]                  accel_mode_ctrl,
    input  wire logic [fpa_pkg::TIM_W-1:0]   fetch_cycle_ctrl,
    // core request and answer
    input  wire fpa_pkg::fpa_req_t           core_req,
    output logic                             core_ready,
    output logic [fpa_pkg::WORD_W-1:0]       core_rdata,
    // flash array
    output logic                             flash_rd,
    output logic [fpa_pkg::LADDR_W-1:0]      flash_laddr,
    input  wire logic [fpa_pkg::LINE_W-1:0]  flash_line,
    input  wire logic                        flash_busy
);
    ////////////////////////////////////////////////////////////////////////////
    typedef enum logic [1:0]
    {
        FPA_ST_IDLE  = 2'b00,
        FPA_ST_FETCH = 2'b01,
        FPA_ST_PREF  = 2'b10
    } fpa_state_t;

    function automatic logic hit(input fpa_pkg::fpa_line_t b, input logic [fpa_pkg::LADDR_W-1:0] la);
        hit = b.valid && (b.laddr == la);
    endfunction

    function automatic logic [fpa_pkg::WORD_W-1:0] pick(input logic [fpa_pkg::LINE_W-1:0] l,
                                                       input logic [fpa_pkg::WSEL_W-1:0] s);
        pick = l[s*fpa_pkg::WORD_W +: fpa_pkg::WORD_W];
    endfunction

    fpa_pkg::fpa_line_t              pf_q, bt_q, dt_q, held_q;
    fpa_state_t                      st_q;
    logic [fpa_pkg::TIM_W-1:0]       cnt_q;
    logic [fpa_pkg::TIM_W-1:0]       tim_q;
    fpa_pkg::fpa_mode_t              mode_q;
    logic                            fetch_data_q, fetch_seq_q, pf_pend_q, busy_q;
    logic [fpa_pkg::LADDR_W-1:0]     pf_addr_q;
    logic [fpa_pkg::LADDR_W-1:0]     req_la;
    logic [fpa_pkg::WSEL_W-1:0]      req_ws;
    logic                            is_instr, use_pf, use_bt, use_dt, use_held, inval, done;
    logic                            pf_wait, any_hit;

    ////////////////////////////////////////////////////////////////////////////
    assign req_la   = core_req.addr[fpa_pkg::ADDR_W-1:fpa_pkg::LADDR_LSB];
    assign req_ws   = core_req.addr[fpa_pkg::LADDR_LSB-1:fpa_pkg::WSEL_LSB];
    assign is_instr = !core_req.prot0;
    // mode 1 buffers sequential code only, mode 2 everything; off uses none
    assign use_pf   = is_instr && (mode_q != fpa_pkg::FPA_MODE_OFF) && hit(pf_q, req_la)
                      && (core_req.seq || mode_q == fpa_pkg::FPA_MODE_FULL);
    assign use_bt   = is_instr && (mode_q == fpa_pkg::FPA_MODE_FULL) && hit(bt_q, req_la);
    assign use_dt   = !is_instr && (mode_q == fpa_pkg::FPA_MODE_FULL) && hit(dt_q, req_la);
    // a finished prefetch is only claimed when the core asks for that line
    assign use_held = is_instr && (mode_q != fpa_pkg::FPA_MODE_OFF) && hit(held_q, req_la);
    assign inval    = (accel_mode_ctrl != mode_q) || (flash_busy && !busy_q);
    assign done     = (st_q != FPA_ST_IDLE) && (cnt_q == tim_q);
    // the line asked for is already on its way from flash: wait, do not reread
    assign pf_wait  = is_instr && pf_pend_q && (pf_addr_q == req_la);
    assign any_hit  = use_pf || use_bt || use_dt || use_held;

    // configuration capture; reserved timing code is ignored
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            mode_q <= fpa_pkg::MODE_RESET;
            tim_q  <= fpa_pkg::TIM_RESET;
            busy_q <= 1'b0;
        end
        else
        begin
            mode_q <= fpa_pkg::fpa_mode_t'(accel_mode_ctrl);
            if (fetch_cycle_ctrl != fpa_pkg::TIM_RSVD)
                tim_q <= fetch_cycle_ctrl;
            busy_q <= flash_busy;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // flash sequencer: one bank, so prefetch and fetch share one slot
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            st_q         <= FPA_ST_IDLE;
            cnt_q        <= fpa_pkg::TIM_ONE;
            flash_rd     <= 1'b0;
            flash_laddr  <= '0;
            fetch_data_q <= 1'b0;
            fetch_seq_q  <= 1'b0;
            pf_pend_q    <= 1'b0;
            pf_addr_q    <= '0;
        end
        else
        begin
            flash_rd <= 1'b0;
            if (st_q != FPA_ST_IDLE)
                cnt_q <= cnt_q + fpa_pkg::TIM_ONE;
            unique case (st_q)
                FPA_ST_IDLE:
                begin
                    cnt_q <= fpa_pkg::TIM_ONE;
                    if (flash_busy)
                        st_q <= FPA_ST_IDLE;
                    else if (core_req.req && !core_ready && !any_hit && !pf_wait)
                    begin
                        st_q         <= FPA_ST_FETCH;
                        flash_rd     <= 1'b1;
                        flash_laddr  <= req_la;
                        fetch_data_q <= !is_instr;
                        fetch_seq_q  <= core_req.seq;
                        if (is_instr)
                        begin
                            // with acceleration off nothing would ever claim it
                            pf_pend_q <= (mode_q != fpa_pkg::FPA_MODE_OFF);
                            pf_addr_q <= req_la + fpa_pkg::LINE_INC;
                        end
                    end
                    else if (pf_pend_q && mode_q != fpa_pkg::FPA_MODE_OFF && !inval)
                    begin
                        st_q        <= FPA_ST_PREF;
                        flash_rd    <= 1'b1;
                        flash_laddr <= pf_addr_q;
                    end
                end
                FPA_ST_FETCH, FPA_ST_PREF:
                begin
                    if (flash_busy)
                        st_q <= FPA_ST_IDLE;
                    else if (done)
                    begin
                        st_q <= FPA_ST_IDLE;
                        if (st_q == FPA_ST_PREF)
                            pf_pend_q <= 1'b0;
                    end
                    else if (st_q == FPA_ST_PREF && core_req.req && !is_instr && !core_ready && !use_dt)
                    begin
                        // the prefetch stays pending and is issued again afterwards
                        st_q         <= FPA_ST_FETCH;
                        cnt_q        <= fpa_pkg::TIM_ONE;
                        flash_rd     <= 1'b1;
                        flash_laddr  <= req_la;
                        fetch_data_q <= 1'b1;
                        fetch_seq_q  <= core_req.seq;
                    end
                end
                default:
                    st_q <= FPA_ST_IDLE;
            endcase
            // claiming a prefetched line chains the prefetch of the line after it
            if (core_req.req && use_held)
            begin
                pf_pend_q <= 1'b1;
                pf_addr_q <= req_la + fpa_pkg::LINE_INC;
            end
            if (inval)
                pf_pend_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // line buffers, each with its own line address latch
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            pf_q   <= '0;
            bt_q   <= '0;
            dt_q   <= '0;
            held_q <= '0;
        end
        else if (inval)
        begin
            pf_q.valid   <= 1'b0;
            bt_q.valid   <= 1'b0;
            dt_q.valid   <= 1'b0;
            held_q.valid <= 1'b0;
        end
        else
        begin
            if (done && st_q == FPA_ST_PREF)
                held_q <= '{valid: 1'b1, laddr: flash_laddr, data: flash_line};
            else if (core_req.req && is_instr && use_held)
            begin
                pf_q         <= held_q;
                held_q.valid <= 1'b0;
            end
            else if (core_req.req && is_instr && !use_pf && !use_bt && held_q.valid)
                held_q.valid <= 1'b0;
            if (done && st_q == FPA_ST_FETCH)
            begin
                if (fetch_data_q)
                    dt_q <= '{valid: 1'b1, laddr: flash_laddr, data: flash_line};
                else if (fetch_seq_q)
                    pf_q <= '{valid: 1'b1, laddr: flash_laddr, data: flash_line};
                else
                    bt_q <= '{valid: 1'b1, laddr: flash_laddr, data: flash_line};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // wait logic: answer one cycle after a pf, bt or dt buffer hit or fetch completion
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            core_ready <= 1'b0;
            core_rdata <= '0;
        end
        else
        begin
            core_ready <= 1'b0;
            if (core_ready || !core_req.req || flash_busy || inval)
                core_ready <= 1'b0;
            else if (use_dt)
            begin
                core_ready <= 1'b1;
                core_rdata <= pick(dt_q.data, req_ws);
            end
            else if (use_bt)
            begin
                core_ready <= 1'b1;
                core_rdata <= pick(bt_q.data, req_ws);
            end
            else if (use_pf)
            begin
                core_ready <= 1'b1;
                core_rdata <= pick(pf_q.data, req_ws);
            end
            else if (done && st_q == FPA_ST_FETCH && flash_laddr == req_la)
            begin
                core_ready <= 1'b1;
                core_rdata <= pick(flash_line, req_ws);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    a_busy_holds: assert property (@(posedge ref_clk) disable iff (!resetn)
        flash_busy |=> !core_ready) else $error("answer given while flash busy");
    a_fetch_length: assert property (@(posedge ref_clk) disable iff (!resetn)
        (flash_rd && !flash_busy && tim_q == fpa_pkg::TIM_ONE && $stable(tim_q)) |-> ##1 (st_q == FPA_ST_IDLE || flash_busy))
        else $error("fetch length wrong");
    a_reset_mode: assert property (@(posedge ref_clk) disable iff (!resetn)
        $rose(resetn) |-> mode_q == fpa_pkg::FPA_MODE_OFF) else $error("mode not off");
    a_inval_clear: assert property (@(posedge ref_clk) disable iff (!resetn)
        inval |=> !pf_q.valid && !bt_q.valid && !dt_q.valid) else $error("buffers kept");
    a_miss_reads: assert property (@(posedge ref_clk) disable iff (!resetn)
        flash_rd |-> $past(st_q) != FPA_ST_FETCH) else $error("read during a fetch");
    a_off_nohit: assert property (@(posedge ref_clk) disable iff (!resetn)
        (mode_q == fpa_pkg::FPA_MODE_OFF && st_q == FPA_ST_IDLE && core_req.req && !core_ready && !flash_busy && !inval)
        |=> flash_rd) else $error("no flash read in off mode");
    a_pref_next: assert property (@(posedge ref_clk) disable iff (!resetn)
        (flash_rd && st_q == FPA_ST_FETCH && !fetch_data_q) |-> pf_addr_q == flash_laddr + fpa_pkg::LINE_INC)
        else $error("prefetch address wrong");
    a_ready_pulse: assert property (@(posedge ref_clk) disable iff (!resetn)
        core_ready |=> !core_ready) else $error("ready longer than a cycle");
endmodule

// *** core/fpa_pkg.sv ***
// package for the flash prefetch accelerator: widths, modes, timing, carriers
package fpa_pkg;
    localparam int LINE_W      = 128;
    localparam int WORD_W      = 32;
    localparam int ADDR_W      = 19;
    localparam int LADDR_W     = 15;
    localparam int LADDR_LSB   = 4;
    localparam int WSEL_LSB    = 2;
    localparam int WSEL_W      = 2;
    localparam int TIM_W       = 3;
    localparam logic [TIM_W-1:0] TIM_RESET = 3'h7;
    localparam logic [TIM_W-1:0] TIM_RSVD  = 3'h0;
    localparam logic [TIM_W-1:0] TIM_ONE   = 3'h1;
    localparam logic [LADDR_W-1:0] LINE_INC = 15'h0001;

    typedef enum logic [1:0]
    {
        FPA_MODE_OFF  = 2'b00,
        FPA_MODE_PART = 2'b01,
        FPA_MODE_FULL = 2'b10,
        FPA_MODE_RSVD = 2'b11
    } fpa_mode_t;

    localparam fpa_mode_t MODE_RESET = FPA_MODE_OFF;

    // one line buffer: valid, line address, contents
    typedef struct packed
    {
        logic               valid;
        logic [LADDR_W-1:0] laddr;
        logic [LINE_W-1:0]  data;
    } fpa_line_t;

    // core request
    typedef struct packed
    {
        logic              req;
        logic              seq;
        logic              prot0;
        logic [ADDR_W-1:0] addr;
    } fpa_req_t;
endpackage

// *** test/fpa_flash_model.sv ***
// flash array model answering line reads for the accelerator bench
`timescale 1ns/1ps
module fpa_flash_model
(
    // clock and reset
    input  wire logic                        ref_clk,
    input  wire logic                        resetn,
    // flash array side
    input  wire logic                        flash_rd,
    input  wire logic [fpa_pkg::LADDR_W-1:0] flash_laddr,
    output logic [fpa_pkg::LINE_W-1:0]       flash_line
);
    // reads seen per line, low five line bits; aborted reads count too
    int rd_cnt [0:31];

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        foreach (rd_cnt[i])
            rd_cnt[i] = 0;
    end

    // line follows the latched address at once, so a one-clock read sees it;
    // word w of line l reads back as {w, zeros, l}
    always_comb
    begin
        for (int w = 0; w < 4; w++)
            flash_line[32*w +: 32] = {2'(w), 15'h0000, flash_laddr};
    end

    always @(posedge ref_clk)
    begin
        if (resetn === 1'b1 && flash_rd === 1'b1)
            rd_cnt[flash_laddr[4:0]] = rd_cnt[flash_laddr[4:0]] + 1;
    end
endmodule

// *** test/fpa_flash_prefetch_accelerator_tb.sv ***
// self-checking bench for the flash prefetch accelerator
`timescale 1ns/1ps
module fpa_flash_prefetch_accelerator_tb;
    logic                        ref_clk;
    logic                        resetn;
    logic [1:0]                  accel_mode_ctrl;
    logic [fpa_pkg::TIM_W-1:0]   fetch_cycle_ctrl;
    fpa_pkg::fpa_req_t           core_req;
    logic                        core_ready;
    logic [fpa_pkg::WORD_W-1:0]  core_rdata;
    logic                        flash_rd;
    logic [fpa_pkg::LADDR_W-1:0] flash_laddr;
    logic [fpa_pkg::LINE_W-1:0]  flash_line;
    logic                        flash_busy;
    int                          n_errors;
    int                          total_checks;
    int                          c;
    int                          l0;
    int                          l1;
    int                          l2;

    fpa_flash_prefetch_accelerator fpa_flash_prefetch_accelerator_i (.ref_clk(ref_clk), .resetn(resetn),
        .accel_mode_ctrl(accel_mode_ctrl), .fetch_cycle_ctrl(fetch_cycle_ctrl), .core_req(core_req),
        .core_ready(core_ready), .core_rdata(core_rdata), .flash_rd(flash_rd), .flash_laddr(flash_laddr),
        .flash_line(flash_line), .flash_busy(flash_busy));
    fpa_flash_model fpa_flash_model_i (.ref_clk(ref_clk), .resetn(resetn), .flash_rd(flash_rd),
        .flash_laddr(flash_laddr), .flash_line(flash_line));

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string nm, input logic [127:0] seen, input logic [127:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic end_of_test();
        if (n_errors == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic idle(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    function automatic int cnt(input int l);
        return fpa_flash_model_i.rd_cnt[l];
    endfunction

    task automatic set_cfg(input logic [1:0] m, input logic [2:0] t);
        @(negedge ref_clk);
        accel_mode_ctrl = m;
        fetch_cycle_ctrl = t;
        idle(12);
    endtask

    // request held until ready, dropped in the ready cycle; lat in cycles
    task automatic fetch(input logic [18:0] a, input logic sq, input logic p0, output int lat);
        @(negedge ref_clk);
        core_req = '{req: 1'b1, seq: sq, prot0: p0, addr: a};
        lat = 0;
        do
        begin
            @(negedge ref_clk);
            lat++;
        end
        while (core_ready !== 1'b1 && lat < 300);
        core_req.req = 1'b0;
        check("ready", core_ready, 1'b1);
        check("rdata", core_rdata, {a[3:2], 15'h0000, a[18:4]});
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        check("ready_rst", core_ready, 1'b0);
        check("rd_rst", flash_rd, 1'b0);
        c = cnt(1);
        fetch(19'h00010, 1'b1, 1'b0, l0);
        check("first_read", cnt(1), c + 1);
    endtask

    // disabled mode reads flash on every request
    task automatic t_off();
        c = cnt(16);
        fetch(19'h00100, 1'b0, 1'b0, l0);
        fetch(19'h00104, 1'b1, 1'b0, l0);
        check("off_reads", cnt(16), c + 2);
    endtask

    task automatic t_seq();
        set_cfg(2'b10, 3'h2);
        c = cnt(4);
        l1 = cnt(5);
        fetch(19'h00040, 1'b0, 1'b0, l0);
        check("miss_read", cnt(4), c + 1);
        for (int w = 1; w < 4; w++)
        begin
            fetch(19'h00040 + 19'(4 * w), 1'b1, 1'b0, l0);
            check("hit_lat", l0 <= 2, 1'b1);
        end
        fetch(19'h00050, 1'b1, 1'b0, l0);
        check("line_reads", cnt(4), c + 1);
        check("pref_once", cnt(5), l1 + 1);
    endtask

    task automatic t_branch();
        idle(12);
        c = cnt(8);
        fetch(19'h00080, 1'b0, 1'b0, l0);
        check("br_stall", l0 > 2, 1'b1);
        fetch(19'h00084, 1'b1, 1'b0, l0);
        fetch(19'h00080, 1'b0, 1'b0, l0);
        check("trail_hit", cnt(8), c + 1);
        set_cfg(2'b01, 3'h2);
        c = cnt(8);
        fetch(19'h00080, 1'b0, 1'b0, l0);
        fetch(19'h00080, 1'b0, 1'b0, l0);
        check("part_branch", cnt(8), c + 2);
    endtask

    task automatic t_data();
        set_cfg(2'b10, 3'h2);
        l2 = cnt(13);
        c = cnt(12);
        fetch(19'h000c0, 1'b0, 1'b1, l0);
        fetch(19'h000c4, 1'b1, 1'b1, l0);
        fetch(19'h000c8, 1'b1, 1'b1, l0);
        check("data_hits", cnt(12), c + 1);
        fetch(19'h000c0, 1'b0, 1'b0, l0);
        check("split_buf", cnt(12), c + 2);
        // data miss while the next code line is being prefetched
        l1 = cnt(20);
        fetch(19'h00140, 1'b0, 1'b1, l0);
        check("data_read", cnt(20), l1 + 1);
        fetch(19'h000d0, 1'b1, 1'b0, l0);
        check("pf_restart", cnt(13), l2 + 2);
        fetch(19'h000c0, 1'b0, 1'b1, l0);
        c = cnt(12);
        set_cfg(2'b01, 3'h2);
        set_cfg(2'b10, 3'h2);
        fetch(19'h000c0, 1'b0, 1'b1, l0);
        check("mode_inval", cnt(12), c + 1);
    endtask

    task automatic t_busy();
        c = cnt(12);
        @(negedge ref_clk);
        flash_busy = 1'b1;
        fork
            begin
                idle(14);
                flash_busy = 1'b0;
            end
            fetch(19'h000c4, 1'b1, 1'b1, l0);
        join
        check("busy_wait", l0 >= 13, 1'b1);
        check("busy_inval", cnt(12), c + 1);
    endtask

    // miss latency must follow the timing field; code 0 keeps the old value
    task automatic t_timing();
        set_cfg(2'b10, 3'h1);
        fetch(19'h00180, 1'b0, 1'b0, l0);
        set_cfg(2'b10, 3'h0);
        fetch(19'h001a0, 1'b0, 1'b0, l1);
        set_cfg(2'b10, 3'h7);
        fetch(19'h001c0, 1'b0, 1'b0, l2);
        check("tim_rsvd", l1, l0);
        check("tim_span", l2 - l0, 6);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    initial
    begin
        #400000;
        n_errors++;
        end_of_test();
    end

    initial
    begin
        n_errors = 0;
        total_checks = 0;
        resetn = 1'b0;
        accel_mode_ctrl = 2'b00;
        fetch_cycle_ctrl = 3'h7;
        core_req = '0;
        flash_busy = 1'b0;
        idle(2);
        resetn = 1'b1;
        t_reset();
        t_off();
        t_seq();
        t_branch();
        t_data();
        t_busy();
        t_timing();
        end_of_test();
    end
endmodule
